/* File: common/byte_port_regs.vh */
/*
  Register map, field positions and reset values of the byte port
  with its three-pin companion port and slave byte port.
  Assumes a 32-bit classic Wishbone slave; byte address = 4 * index.
*/
`ifndef BYTE_PORT_REGS_VH
`define BYTE_PORT_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_WIDE_PORT_PINS      8'h08
`define IDX_NARROW_PORT_PINS    8'h09
`define IDX_WIDE_PORT_DIRECTION 8'h88
`define IDX_NARROW_DIR_STATUS   8'h89
`define IDX_ANALOG_PIN_CONFIG   8'h9F
`define IDX_SLAVE_IRQ_FLAG      8'hA0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_INBOUND_FULL        7
`define BIT_OUTBOUND_FULL       6
`define BIT_INBOUND_OVERRUN     5
`define BIT_SLAVE_PORT_SELECT   4
`define BIT_SLAVE_IRQ_FLAG      0
`define ANALOG_SELECT_MSB       3
`define ANALOG_CFG_MASK         8'hCF

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define RST_WIDE_DIRECTION      8'hFF
`define RST_NARROW_DIRECTION    3'h7
`define RST_ANALOG_PIN_CONFIG   8'h00
`define RST_WIDE_LATCH          8'h00
`define RST_NARROW_LATCH        3'h0
`define WB_ADR_WIDTH            10
`define WB_IDX_MSB              9
`define WB_IDX_LSB              2
`define RST_WIDE_OE             8'h00
`define RST_NARROW_OE           3'h0
`define RST_BUS_DATA            32'h00000000
`define WIDE_PIN_COUNT          8
`define NARROW_PIN_COUNT        3
`define NARROW_DIR_MSB          2
`define STROBE_READ_BIT         0
`define STROBE_STORE_BIT        1
`define STROBE_SELECT_BIT       2

`endif

/* File: design/byte_port_with_slave_port_ctrl.v */
/*
  Eight-pin byte port and three-pin companion port with per-pin
  direction, analog pin masking on the companion port, and a slave
  byte port driven by an external 8-bit bus through active-low read,
  write and chip-select strobes on the companion pins.
  Assumes: a 25 MHz sys_clk, synchronous active-low nrst, a classic
  Wishbone master, and pin buffers resolved outside from out and oe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "byte_port_regs.vh"

module byte_port_with_slave_port_ctrl #(
  parameter [3:0] DIGITAL_FIELD_CODE = 4'hF
) (
  input  wire                     sys_clk,
  input  wire                     nrst,
  input  wire                     wb_cyc_i,
  input  wire                     wb_stb_i,
  input  wire                     wb_we_i,
  input  wire [`WB_ADR_WIDTH-1:0] wb_adr_i,
  input  wire [3:0]               wb_sel_i,
  input  wire [31:0]              wb_dat_i,
  output reg  [31:0]              wb_dat_o,
  output reg                      wb_ack_o,
  input  wire [7:0]               wide_pins_in,
  output reg  [7:0]               wide_pins_out,
  output reg  [7:0]               wide_pins_oe,
  input  wire [2:0]               narrow_pins_in,
  output reg  [2:0]               narrow_pins_out,
  output reg  [2:0]               narrow_pins_oe,
  output reg                      slave_port_irq_flag
);

  // ----------------------------------------------------------------
  // Pin synchronisers, two flops per pin
  // ----------------------------------------------------------------
  localparam ALL_PINS = `WIDE_PIN_COUNT + `NARROW_PIN_COUNT;

  wire [ALL_PINS-1:0] pins_raw    = {narrow_pins_in, wide_pins_in};
  wire [ALL_PINS-1:0] pins_sync;
  wire [7:0]          wide_sync   = pins_sync[`WIDE_PIN_COUNT-1:0];
  wire [2:0]          narrow_sync = pins_sync[ALL_PINS-1:`WIDE_PIN_COUNT];

  genvar pin;

  generate
    for (pin = 0; pin < ALL_PINS; pin = pin + 1)
    begin : sync_bit
      reg meta;
      reg held;

      always @(posedge sys_clk)
      begin
        meta <= pins_raw[pin];
        held <= meta;
      end

      assign pins_sync[pin] = held;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control and status state
  // ----------------------------------------------------------------
  reg  [7:0] wide_latch;
  reg  [7:0] input_latch;
  reg  [7:0] wide_direction;
  reg  [2:0] narrow_latch;
  reg  [2:0] narrow_direction;
  reg        slave_port_select;
  reg        inbound_full;
  reg        outbound_full;
  reg        inbound_overrun;
  reg  [7:0] analog_pin_config;
  reg        write_active_q;
  reg        read_active_q;

  reg  [7:0] next_wide_latch;
  reg  [7:0] next_input_latch;
  reg  [7:0] next_wide_direction;
  reg  [2:0] next_narrow_latch;
  reg  [2:0] next_narrow_direction;
  reg        next_slave_port_select;
  reg        next_inbound_full;
  reg        next_outbound_full;
  reg        next_inbound_overrun;
  reg  [7:0] next_analog_pin_config;
  reg        next_irq_flag;
  reg  [31:0] next_dat;
  reg  [7:0] next_wide_oe;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  wire [3:0] analog_select_field = analog_pin_config[`ANALOG_SELECT_MSB:0];
  wire       narrow_digital = (analog_select_field == DIGITAL_FIELD_CODE);
  wire       read_strobe_n  = narrow_sync[`STROBE_READ_BIT];
  wire       store_strobe_n = narrow_sync[`STROBE_STORE_BIT];
  wire       chip_select_n  = narrow_sync[`STROBE_SELECT_BIT];
  wire       write_active   = slave_port_select & ~chip_select_n
                              & ~store_strobe_n;
  wire       read_active    = slave_port_select & ~chip_select_n
                              & ~read_strobe_n;
  wire       write_end      = write_active_q & ~write_active;
  wire       read_end       = read_active_q & ~read_active;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [7:0] bus_idx  = wb_adr_i[`WB_IDX_MSB:`WB_IDX_LSB];
  wire       bus_req  = wb_cyc_i & wb_stb_i;
  wire       bus_done = bus_req & wb_ack_o;
  wire       bus_wr   = bus_done & wb_we_i & wb_sel_i[0];
  wire       bus_rd   = bus_done & ~wb_we_i;
  wire [7:0] wdat     = wb_dat_i[7:0];

  wire [7:0] narrow_status = {inbound_full, outbound_full,
                              inbound_overrun, slave_port_select,
                              1'b0, narrow_direction};
  wire [2:0] narrow_read   = narrow_digital ? narrow_sync
                                            : 3'h0;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @*
  begin
    next_dat = 32'h00000000;
    case (bus_idx)
      `IDX_WIDE_PORT_PINS:
        next_dat[7:0] = slave_port_select ? input_latch : wide_sync;
      `IDX_NARROW_PORT_PINS:
        next_dat[2:0] = narrow_read;
      `IDX_WIDE_PORT_DIRECTION:
        next_dat[7:0] = wide_direction;
      `IDX_NARROW_DIR_STATUS:
        next_dat[7:0] = narrow_status;
      `IDX_ANALOG_PIN_CONFIG:
        next_dat[7:0] = analog_pin_config;
      `IDX_SLAVE_IRQ_FLAG:
        next_dat[`BIT_SLAVE_IRQ_FLAG] = slave_port_irq_flag;
      default:
        next_dat = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state of registers and flags
  // ----------------------------------------------------------------
  always @*
  begin
    next_wide_latch        = wide_latch;
    next_input_latch       = input_latch;
    next_wide_direction    = wide_direction;
    next_narrow_latch      = narrow_latch;
    next_narrow_direction  = narrow_direction;
    next_slave_port_select = slave_port_select;
    next_inbound_full      = inbound_full;
    next_outbound_full     = outbound_full;
    next_inbound_overrun   = inbound_overrun;
    next_analog_pin_config = analog_pin_config;
    next_irq_flag          = slave_port_irq_flag;

    // Software writes and read side effects; clears go first
    if (bus_wr)
    begin
      case (bus_idx)
        `IDX_WIDE_PORT_PINS:
        begin
          next_wide_latch = wdat;
          if (slave_port_select)
            next_outbound_full = 1'b1;
        end
        `IDX_NARROW_PORT_PINS:
          next_narrow_latch = wdat[`NARROW_DIR_MSB:0];
        `IDX_WIDE_PORT_DIRECTION:
          next_wide_direction = wdat;
        `IDX_NARROW_DIR_STATUS:
        begin
          next_narrow_direction  = wdat[`NARROW_DIR_MSB:0];
          next_slave_port_select = wdat[`BIT_SLAVE_PORT_SELECT];
          next_inbound_overrun   = inbound_overrun
                                   & wdat[`BIT_INBOUND_OVERRUN];
        end
        `IDX_ANALOG_PIN_CONFIG:
          next_analog_pin_config = wdat & `ANALOG_CFG_MASK;
        `IDX_SLAVE_IRQ_FLAG:
          next_irq_flag = slave_port_irq_flag & wdat[`BIT_SLAVE_IRQ_FLAG];
        default:
          next_irq_flag = slave_port_irq_flag;
      endcase
    end
    if (bus_rd && bus_idx == `IDX_WIDE_PORT_PINS && slave_port_select)
      next_inbound_full = 1'b0;

    // External bus events; a set wins over a same-cycle clear
    if (write_active)
      next_input_latch = wide_sync;
    if (read_active && !(bus_wr && bus_idx == `IDX_WIDE_PORT_PINS))
      next_outbound_full = 1'b0;
    if (write_end)
    begin
      next_inbound_full = 1'b1;
      next_irq_flag     = 1'b1;
      if (inbound_full)
        next_inbound_overrun = 1'b1;
    end
    if (read_end)
      next_irq_flag = 1'b1;

    // Outside slave mode the full flags stay clear
    if (!next_slave_port_select)
    begin
      next_inbound_full  = 1'b0;
      next_outbound_full = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Byte-port pin drive
  // ----------------------------------------------------------------
  always @*
  begin
    if (slave_port_select)
      next_wide_oe = {8{read_active}};
    else
      next_wide_oe = ~wide_direction;
  end

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wide_latch          <= `RST_WIDE_LATCH;
      input_latch         <= `RST_WIDE_LATCH;
      wide_direction      <= `RST_WIDE_DIRECTION;
      narrow_latch        <= `RST_NARROW_LATCH;
      narrow_direction    <= `RST_NARROW_DIRECTION;
      slave_port_select   <= 1'b0;
      inbound_full        <= 1'b0;
      outbound_full       <= 1'b0;
      inbound_overrun     <= 1'b0;
      analog_pin_config   <= `RST_ANALOG_PIN_CONFIG;
      slave_port_irq_flag <= 1'b0;
      write_active_q      <= 1'b0;
      read_active_q       <= 1'b0;
    end
    else
    begin
      wide_latch          <= next_wide_latch;
      input_latch         <= next_input_latch;
      wide_direction      <= next_wide_direction;
      narrow_latch        <= next_narrow_latch;
      narrow_direction    <= next_narrow_direction;
      slave_port_select   <= next_slave_port_select;
      inbound_full        <= next_inbound_full;
      outbound_full       <= next_outbound_full;
      inbound_overrun     <= next_inbound_overrun;
      analog_pin_config   <= next_analog_pin_config;
      slave_port_irq_flag <= next_irq_flag;
      write_active_q      <= write_active;
      read_active_q       <= read_active;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait state, read data taken with the request
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RST_BUS_DATA;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      if (bus_req && !wb_ack_o)
        wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      wide_pins_out   <= `RST_WIDE_LATCH;
      wide_pins_oe    <= `RST_WIDE_OE;
      narrow_pins_out <= `RST_NARROW_LATCH;
      narrow_pins_oe  <= `RST_NARROW_OE;
    end
    else
    begin
      wide_pins_out   <= next_wide_latch;
      wide_pins_oe    <= next_wide_oe;
      narrow_pins_out <= next_narrow_latch;
      narrow_pins_oe  <= ~next_narrow_direction;
    end
  end

endmodule
`default_nettype wire

/* File: verification/byte_port_chk.sv */
/*
  Checker for the byte port block: bus handshake, reset state and
  slave port drive and flag timing.
  Assumes it is bound to the design top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
`include "byte_port_regs.vh"
module byte_port_chk (
  input wire logic                     sys_clk,
  input wire logic                     nrst,
  input wire logic                     wb_cyc_i,
  input wire logic                     wb_stb_i,
  input wire logic                     wb_we_i,
  input wire logic [`WB_ADR_WIDTH-1:0] wb_adr_i,
  input wire logic [3:0]               wb_sel_i,
  input wire logic [31:0]              wb_dat_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic [7:0]               wide_pins_in,
  input wire logic [7:0]               wide_pins_out,
  input wire logic [7:0]               wide_pins_oe,
  input wire logic [2:0]               narrow_pins_in,
  input wire logic [2:0]               narrow_pins_out,
  input wire logic [2:0]               narrow_pins_oe,
  input wire logic                     slave_port_irq_flag
);
  logic mode;
  // --------------------------------------------------------------
  // Shadow of the slave select bit, taken from bus writes
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk)
    if (!nrst)
      mode <= 1'b0;
    else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == `IDX_NARROW_DIR_STATUS)
      mode <= wb_dat_i[`BIT_SLAVE_PORT_SELECT];
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_ACK_ONE:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_CAUSE:
    assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without request");
  AST_RESET_OE:
    assert property ($rose(nrst) |-> wide_pins_oe == 8'h00 && narrow_pins_oe == 3'h0)
    else $error("pins driven after reset");
  AST_RESET_OUT:
    assert property ($rose(nrst) |-> narrow_pins_out == 3'h0 && !slave_port_irq_flag)
    else $error("outputs not cleared by reset");
  AST_READ_DRIVE:
    assert property ((mode && narrow_pins_in == 3'b010)[*5] |-> wide_pins_oe == 8'hFF)
    else $error("byte port not driven during read");
  AST_SLAVE_IDLE:
    assert property ((mode && narrow_pins_in == 3'b111)[*5] |-> wide_pins_oe == 8'h00)
    else $error("byte port driven while slave idle");
  AST_IRQ_WRITE:
    assert property ((mode && narrow_pins_in == 3'b001)[*4] ##1
      (mode && narrow_pins_in == 3'b111 && !wb_cyc_i)[*5] |-> slave_port_irq_flag)
    else $error("flag not set after external write");
  AST_IRQ_HOLD:
    assert property (slave_port_irq_flag && !wb_we_i |=> slave_port_irq_flag)
    else $error("flag dropped without a write");
endmodule
bind byte_port_with_slave_port_ctrl byte_port_chk byte_port_chk_i (
  .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wide_pins_in(wide_pins_in),
  .wide_pins_out(wide_pins_out), .wide_pins_oe(wide_pins_oe),
  .narrow_pins_in(narrow_pins_in), .narrow_pins_out(narrow_pins_out),
  .narrow_pins_oe(narrow_pins_oe), .slave_port_irq_flag(slave_port_irq_flag));
`default_nettype wire

/* File: verification/byte_port_with_slave_port_ctrl_tb.sv */
/*
  Self-checking bench: register map, general I/O, slave byte port.
  Assumes the design, its bound checker and ext_bus_model.
*/
`timescale 1ns/1ns
`default_nettype none
`include "byte_port_regs.vh"
module byte_port_with_slave_port_ctrl_tb;
  logic        sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [7:0]  wide_in, wide_out, wide_oe, q;
  logic [2:0]  nar_in, nar_out, nar_oe, strb;
  int          n_mismatch = 0, tests_run = 0, cycles = 0;
  logic [3:0]  sel_lane = 4'hF;
  assign nar_in = (nar_oe & nar_out) | (~nar_oe & strb);
  byte_port_with_slave_port_ctrl byte_port_with_slave_port_ctrl_i (
    .sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wide_pins_in(wide_in),
    .wide_pins_out(wide_out), .wide_pins_oe(wide_oe), .narrow_pins_in(nar_in),
    .narrow_pins_out(nar_out), .narrow_pins_oe(nar_oe), .slave_port_irq_flag(irq));
  ext_bus_model ext_bus_model_i (.clk(sys_clk), .dev_out(wide_out), .dev_oe(wide_oe),
    .pins(wide_in), .strobes_n(strb));
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_sel_i <= sel_lane;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    chk(nm, e, q);
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdchk("wdir", `IDX_WIDE_PORT_DIRECTION, 8'hFF);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h07);
    rdchk("acfg", `IDX_ANALOG_PIN_CONFIG, 8'h00);
    rdchk("npins", `IDX_NARROW_PORT_PINS, 8'h00);
    rdchk("unmapped", 8'h10, 8'h00);
    chk("noe", 8'h00, {5'h00, nar_oe});
  endtask
  task automatic t_gpio();
    wb(1'b1, `IDX_WIDE_PORT_DIRECTION, 8'h5A);
    wb(1'b1, `IDX_WIDE_PORT_PINS, 8'h3C);
    wb(1'b1, `IDX_NARROW_DIR_STATUS, 8'h0A);
    wb(1'b1, `IDX_NARROW_PORT_PINS, 8'hFC);
    repeat (3) @(posedge sys_clk);
    chk("woe", 8'hA5, wide_oe);
    chk("wout", 8'h3C, wide_out);
    chk("noe", 8'h05, {5'h00, nar_oe});
    chk("nout", 8'h04, {5'h00, nar_out});
    rdchk("wpins", `IDX_WIDE_PORT_PINS, 8'h7E);
    sel_lane = 4'hE;
    wb(1'b1, `IDX_WIDE_PORT_DIRECTION, 8'h00);
    sel_lane = 4'hF;
    rdchk("wdir", `IDX_WIDE_PORT_DIRECTION, 8'h5A);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h02);
    rdchk("npins", `IDX_NARROW_PORT_PINS, 8'h00);
    wb(1'b1, `IDX_ANALOG_PIN_CONFIG, 8'hFF);
    rdchk("acfg", `IDX_ANALOG_PIN_CONFIG, 8'hCF);
    rdchk("npins", `IDX_NARROW_PORT_PINS, 8'h06);
    wb(1'b1, `IDX_NARROW_DIR_STATUS, 8'h07);
  endtask
  task automatic t_slave();
    wb(1'b1, `IDX_NARROW_DIR_STATUS, 8'h17);
    repeat (6) @(posedge sys_clk);
    chk("woe", 8'h00, wide_oe);
    wb(1'b1, `IDX_WIDE_PORT_PINS, 8'hC3);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h57);
    ext_bus_model_i.ext_read(q);
    chk("ext_read", 8'hC3, q);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h17);
    chk("irq", 8'h01, {7'h00, irq});
    wb(1'b1, `IDX_SLAVE_IRQ_FLAG, 8'h00);
    rdchk("irqreg", `IDX_SLAVE_IRQ_FLAG, 8'h00);
    ext_bus_model_i.ext_write(8'h96);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h97);
    chk("irq", 8'h01, {7'h00, irq});
    ext_bus_model_i.ext_write(8'h69);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'hB7);
    rdchk("wpins", `IDX_WIDE_PORT_PINS, 8'h69);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h37);
    wb(1'b1, `IDX_WIDE_PORT_PINS, 8'h11);
    wb(1'b1, `IDX_NARROW_DIR_STATUS, 8'h27);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h27);
    wb(1'b1, `IDX_NARROW_DIR_STATUS, 8'h07);
    rdchk("stat", `IDX_NARROW_DIR_STATUS, 8'h07);
  endtask
  initial
  begin
    nrst = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_gpio();
    t_slave();
    conclude();
  end
endmodule
`default_nettype wire

/* File: verification/ext_bus_model.sv */
/*
  External 8-bit bus master facing the slave byte port.
  Assumes the design's byte-port output and enable come in; gives
  back the resolved wire level and the three active-low strobes.
*/
`timescale 1ns/1ns
`default_nettype none
module ext_bus_model (
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe,
  input  wire logic       clk,
  output wire logic [7:0] pins,
  output var  logic [2:0] strobes_n
);
  logic [7:0] drv = 8'h00;
  logic [7:0] last = 8'h00;
  logic       drv_en = 1'b0;
  initial strobes_n = 3'h7;
  // Undriven bits show the inverse of their last driven level
  assign pins = (dev_oe & dev_out) | (~dev_oe & (drv_en ? drv : ~last));
  always @(posedge clk)
    if (!$isunknown({dev_oe, dev_out}))
      last <= (dev_oe & dev_out) | (~dev_oe & (drv_en ? drv : last));
  task automatic ext_write(input logic [7:0] d);
    @(posedge clk);
    drv <= d;
    drv_en <= 1'b1;
    strobes_n <= 3'b001;
    repeat (4) @(posedge clk);
    strobes_n <= 3'h7;
    repeat (4) @(posedge clk);
    drv_en <= 1'b0;
  endtask
  task automatic ext_read(output logic [7:0] d);
    @(posedge clk);
    strobes_n <= 3'b010;
    repeat (6) @(posedge clk);
    d = pins;
    strobes_n <= 3'h7;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire
